/* shared/acc_defines.vh */
// Constants for the analog command conditioning block
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH
`define ACC_MID        8'h80
`define ACC_SYNC_RESET 8'h00
`define ACC_FULL       8'h7f
`define ACC_DB_RESET   3'h3
`define ACC_DB_STEP    8'h03
`define ACC_SAT_MARGIN 8'h06
`define ACC_CURVE_LIN  3'h0
`define ACC_CURVE_EXP  3'h1
`define ACC_CURVE_LOG  3'h2
`define ACC_FB_OPEN    2'h0
`define ACC_FB_ENC     2'h1
`define ACC_FB_ANALOG  2'h2
`define ACC_FB_RSVD    2'h3
`define ACC_ST_HOLD    2'h0
`define ACC_ST_RUN     2'h1
`endif

/* src/acc_channel.v */
// One channel: conversion, deadband with rescale, and curve
`include "acc_defines.vh"
module acc_channel (
  input  wire [7:0] code_i,
  input  wire [2:0] db_i,
  input  wire [2:0] curve_i,
  output reg  [7:0] cmd_o,
  output reg        centred_o
);
  reg  [7:0]  mag;
  reg         neg;
  reg  [7:0]  band;
  reg  [7:0]  span;
  reg  [15:0] prod;
  reg  [7:0]  lin;
  reg  [15:0] sq;
  reg  [7:0]  shaped;
  reg  [15:0] quo;
  reg  [15:0] tmp;
  always @* begin
    quo = 16'h0000;
    tmp = 16'h0000;
    // Offset binary to sign and magnitude, clipped to 127
    neg = (code_i < `ACC_MID);
    mag = neg ? (`ACC_MID - code_i) : (code_i - `ACC_MID);
    if (mag > `ACC_FULL)
      mag = `ACC_FULL;
    band = db_i * `ACC_DB_STEP;
    centred_o = (mag <= band);
    span = `ACC_FULL - band - `ACC_SAT_MARGIN;
    prod = 16'h0000;
    lin = 8'h00;
    if (mag > band) begin
      prod = (mag - band) * `ACC_FULL;
      if (mag >= band + span)
        lin = `ACC_FULL;
      else begin
        quo = prod / {8'h00, span};
        lin = quo[7:0];
      end
    end
    sq = lin * lin;
    case (curve_i)
      `ACC_CURVE_EXP: begin
        tmp    = sq / {8'h00, `ACC_FULL};
        shaped = tmp[7:0];
      end
      `ACC_CURVE_LOG: begin
        // Sixteen bits wide so the product does not wrap
        tmp    = (({8'h00, `ACC_FULL} - {8'h00, lin}) * {8'h00, lin}) / {8'h00, `ACC_FULL};
        shaped = lin + {1'b0, tmp[7:1]};
      end
      default: begin
        shaped = lin;
      end
    endcase
    cmd_o = neg ? (8'h00 - shaped) : shaped;
  end
endmodule // acc_channel

/* src/acc_top.v */
// Analog command conditioning top: sync, config, mixing and safety hold
`include "acc_defines.vh"
module acc_top (
  input  wire       mclk_i,
  input  wire       arst_n_i,
  input  wire [7:0] ch1_code_i,
  input  wire [7:0] ch2_code_i,
  input  wire [2:0] db_cfg_i,
  input  wire       db_load_i,
  input  wire [2:0] curve_cfg_i,
  input  wire       mixed_i,
  input  wire [1:0] fb_sel_i,
  input  wire       pwr_ctrl_i,
  input  wire       undervolt_i,
  output reg  [7:0] m1_cmd_o,
  output reg  [7:0] m2_cmd_o,
  output reg        motor_en_o,
  output reg        not_centred_o,
  output reg  [2:0] db_o,
  output reg        fb_err_o
);
  // ***************************************
  // Input synchronisers
  // ***************************************
  // Converter words are sampled asynchronously; levels only, held steady
  reg [7:0] c1_s1, c1_s2, c2_s1, c2_s2;
  reg       uv_s1, uv_s2, pc_s1, pc_s2;
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // Reset off-centre, so the hold cannot release before real codes arrive
      c1_s1 <= `ACC_SYNC_RESET;
      c1_s2 <= `ACC_SYNC_RESET;
      c2_s1 <= `ACC_SYNC_RESET;
      c2_s2 <= `ACC_SYNC_RESET;
      uv_s1 <= 1'b0;
      uv_s2 <= 1'b0;
      pc_s1 <= 1'b0;
      pc_s2 <= 1'b0;
    end else begin
      c1_s1 <= ch1_code_i;
      c1_s2 <= c1_s1;
      c2_s1 <= ch2_code_i;
      c2_s2 <= c2_s1;
      uv_s1 <= undervolt_i;
      uv_s2 <= uv_s1;
      pc_s1 <= pwr_ctrl_i;
      pc_s2 <= pc_s1;
    end
  end

  // ***************************************
  // Stored deadband parameter
  // ***************************************
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      db_o <= `ACC_DB_RESET;
    else if (db_load_i)
      db_o <= db_cfg_i;
  end

  // ***************************************
  // Channel conditioning
  // ***************************************
  wire [7:0] s1, s2;
  wire       cen1, cen2;
  acc_channel u_ch1 (
    .code_i    (c1_s2),
    .db_i      (db_o),
    .curve_i   (curve_cfg_i),
    .cmd_o     (s1),
    .centred_o (cen1)
  );
  acc_channel u_ch2 (
    .code_i    (c2_s2),
    .db_i      (db_o),
    .curve_i   (curve_cfg_i),
    .cmd_o     (s2),
    .centred_o (cen2)
  );

  // Saturating signed add, used for both mixed outputs
  function [7:0] sat_add;
    input [7:0] a;
    input [7:0] b;
    reg   [8:0] s;
    begin
      s = {a[7], a} + {b[7], b};
      if (!s[8] && s[7])
        sat_add = `ACC_FULL;
      else if (s[8] && !s[7])
        sat_add = 8'h00 - `ACC_FULL;
      else
        sat_add = s[7:0];
    end
  endfunction

  reg [7:0] next_m1, next_m2;
  always @* begin
    if (mixed_i) begin
      next_m1 = sat_add(s1, s2);
      next_m2 = sat_add(s1, 8'h00 - s2);
    end else begin
      next_m1 = s1;
      next_m2 = s2;
    end
  end

  // ***************************************
  // Safety hold state machine
  // ***************************************
  // Analog feedback is refused: its input is taken by the command
  wire fb_bad = (fb_sel_i == `ACC_FB_ANALOG) || (fb_sel_i == `ACC_FB_RSVD);
  wire uv_trip = pc_s2 && uv_s2;
  reg  [1:0] state;
  reg  [1:0] next_state;
  always @* begin
    case (state)
      `ACC_ST_HOLD: next_state = (cen1 && cen2 && !uv_trip) ? `ACC_ST_RUN : `ACC_ST_HOLD;
      `ACC_ST_RUN:  next_state = uv_trip ? `ACC_ST_HOLD : `ACC_ST_RUN;
      default:      next_state = `ACC_ST_HOLD;
    endcase
  end

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state         <= `ACC_ST_HOLD;
      m1_cmd_o      <= 8'h00;
      m2_cmd_o      <= 8'h00;
      motor_en_o    <= 1'b0;
      not_centred_o <= 1'b1;
      fb_err_o      <= 1'b0;
    end else begin
      state         <= next_state;
      fb_err_o      <= fb_bad;
      not_centred_o <= (next_state == `ACC_ST_HOLD);
      // Outputs forced to zero while holding, so no jump on release
      if (next_state == `ACC_ST_RUN && !fb_bad) begin
        motor_en_o <= 1'b1;
        m1_cmd_o   <= next_m1;
        m2_cmd_o   <= next_m2;
      end else begin
        motor_en_o <= 1'b0;
        m1_cmd_o   <= 8'h00;
        m2_cmd_o   <= 8'h00;
      end
    end
  end
endmodule // acc_top

/* test/acc_pot.sv */
// Potentiometer source model for one command input
module acc_pot (
  input  wire       wired_i,
  input  wire [7:0] level_i,
  output wire [7:0] code_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Unwired input rests at mid-scale through the divider
  assign code_o = wired_i ? level_i : 8'h80;
endmodule // acc_pot

/* test/acc_top_chk.sv */
// Property checker for the conditioning top
module acc_top_chk (
  input wire       mclk_i,
  input wire       arst_n_i,
  input wire [2:0] db_cfg_i,
  input wire       db_load_i,
  input wire [1:0] fb_sel_i,
  input wire [7:0] m1_cmd_o,
  input wire [7:0] m2_cmd_o,
  input wire       motor_en_o,
  input wire       not_centred_o,
  input wire [2:0] db_o,
  input wire       fb_err_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  hold_zero_a: assert property (not_centred_o |-> !m1_cmd_o && !m2_cmd_o)
    else $error("command nonzero while holding");
  hold_off_a: assert property (not_centred_o |-> !motor_en_o)
    else $error("motors enabled while holding");
  fb_set_a: assert property (fb_sel_i[1] |=> fb_err_o)
    else $error("feedback error not raised");
  fb_clear_a: assert property (!fb_sel_i[1] |=> !fb_err_o)
    else $error("feedback error raised wrongly");
  fb_off_a: assert property (fb_err_o |-> !motor_en_o)
    else $error("motors enabled with bad feedback");
  db_load_a: assert property (db_load_i |=> db_o == $past(db_cfg_i))
    else $error("deadband not stored");
  db_keep_a: assert property (!db_load_i |=> $stable(db_o))
    else $error("deadband changed without load");
  cmd_range_a: assert property (m1_cmd_o != 8'h80 && m2_cmd_o != 8'h80)
    else $error("command outside signed range");
endmodule // acc_top_chk
bind acc_top acc_top_chk acc_top_chk_i (.*);

/* test/test_acc.sv */
// Self-checking bench for the conditioning top
module test_analog_command_conditioning;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, load = 0, mix = 0, pwr = 0, uv = 0, w1 = 1, w2 = 1;
  logic [7:0] l1 = 8'hff, l2 = 8'h80;
  logic [2:0] dbc = 3'h0, crv = 3'h0;
  logic [1:0] fb = 2'h1;
  wire  [7:0] c1, c2, m1, m2;
  wire  [2:0] db;
  wire        en, nc, fe;
  int n_errors = 0, n_compared = 0;
  acc_pot acc_pot_i (.wired_i(w1), .level_i(l1), .code_o(c1));
  acc_pot acc_pot_i2 (.wired_i(w2), .level_i(l2), .code_o(c2));
  acc_top acc_top_i (.mclk_i(clk), .arst_n_i(rst_n), .ch1_code_i(c1), .ch2_code_i(c2),
    .db_cfg_i(dbc), .db_load_i(load), .curve_cfg_i(crv), .mixed_i(mix), .fb_sel_i(fb),
    .pwr_ctrl_i(pwr), .undervolt_i(uv), .m1_cmd_o(m1), .m2_cmd_o(m2), .motor_en_o(en),
    .not_centred_o(nc), .db_o(db), .fb_err_o(fe));
  initial forever #10 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Codes need 3 edges to reach the outputs, so 4 is safe
  task automatic drive(input logic [7:0] a, input logic [7:0] b);
    @(negedge clk);
    l1 = a;
    l2 = b;
    repeat (4) @(negedge clk);
  endtask
  task automatic ld(input logic [2:0] d);
    @(negedge clk);
    dbc = d;
    load = 1;
    @(negedge clk);
    load = 0;
    chk({5'h0, db}, {5'h0, d});
  endtask
  task automatic t_hold;
    drive(8'hff, 8'h80);
    chk({nc, en, 6'h0}, 8'h80);
    w1 = 0;
    drive(8'hff, 8'h80);
    chk({nc, en, 6'h0}, 8'h40);
    w1 = 1;
  endtask
  task automatic t_map;
    ld(3'h0);
    drive(8'hff, 8'h00);
    chk(m1, 8'h7f);
    chk(m2, 8'h81);
    drive(8'hfa, 8'h80);
    chk(m1, 8'h7f);
  endtask
  task automatic t_db;
    ld(3'h7);
    drive(8'h95, 8'h6b);
    chk(m1 | m2, 8'h00);
    drive(8'h96, 8'h80);
    chk(m1, 8'h01);
  endtask
  task automatic t_mix_curve;
    ld(3'h0);
    mix = 1;
    drive(8'h90, 8'h80);
    chk(m2, 8'h10);
    chk(m1, 8'h10);
    mix = 0;
    crv = 3'h1;
    drive(8'hbd, 8'h80);
    chk(m1, 8'h20);
    crv = 3'h2;
    drive(8'hbd, 8'h80);
    chk(m1, 8'h4f);
    crv = 3'h0;
  endtask
  task automatic t_fb_uv;
    @(negedge clk);
    fb = 2'h2;
    drive(8'h80, 8'h80);
    chk({fe, en, 6'h0}, 8'h80);
    fb = 2'h1;
    pwr = 1;
    uv = 1;
    drive(8'h80, 8'h80);
    chk({nc, en, 6'h0}, 8'h80);
    uv = 0;
    drive(8'h80, 8'h80);
    chk({nc, en, 6'h0}, 8'h40);
  endtask
  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    t_hold;
    t_map;
    t_db;
    t_mix_curve;
    t_fb_uv;
    final_report;
  end
  // Whole run is about 90 cycles; this limit is far beyond it
  initial begin
    #20000;
    n_errors++;
    final_report;
  end
endmodule // test_analog_command_conditioning
